// >>> lpm_pin_mux.sv
/*
  LCD segment pin function mux: AXI4-Lite register file plus the per-pin
  selection between GPIO, LCD segment/backplane, timer A, serial data and
  analog routing. Port pin vector: bits 0-3 are P3.0-P3.3, bit 4+k carries
  segment k (P4.0 .. P9.0 = segment 35). Inputs are synchronous to aclk.
*/
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "lpm_cfg.svh"
module lpm_pin_mux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire lpm_pkg::lpm_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire lpm_pkg::lpm_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire lpm_pkg::lpm_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output lpm_pkg::lpm_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lpm_pkg::lpm_pins_t gpio_out,
  input wire lpm_pkg::lpm_pins_t gpio_oe,
  output lpm_pkg::lpm_pins_t gpio_in,
  input wire logic p91_gpio_out,
  input wire logic p91_gpio_oe,
  output logic p91_gpio_in,
  input wire lpm_pkg::lpm_seg_t lcd_segment_lines,
  input wire lpm_pkg::lpm_bp_t lcd_backplane_lines,
  input wire logic timer_a_channel_zero_out,
  input wire logic timer_a_channel_zero_oe,
  output logic timer_a_channel_zero_in,
  input wire logic timer_a_channel_one_out,
  input wire logic timer_a_channel_one_oe,
  output logic timer_a_channel_one_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  output logic serial_data_in,
  output logic second_reference_pulse_in,
  input wire lpm_pkg::lpm_pins_t port_pin_in,
  output lpm_pkg::lpm_pins_t port_pin_out,
  output lpm_pkg::lpm_pins_t port_pin_oe,
  input wire logic p91_pin_in,
  output logic p91_pin_out,
  output logic p91_pin_oe,
  output logic seg36_pin_out,
  output logic [2:0] analog_pin_out,
  output logic [2:0] analog_pin_oe,
  output logic [2:0] analog_measure_inputs,
  output logic [1:0] analog_comparator_b
);
  import lpm_pkg::*;

  localparam int NPIN = `LPM_NPORT_PIN;
  localparam lpm_state_s RST_STATE = '{
    lcd_control_register: `LPM_RST_LCD_CTRL,
    peripheral_control_zero: `LPM_RST_PERI_CTRL0,
    port9_function_select: `LPM_RST_PORT9_FS,
    seg_en: `LPM_RST_SEG_EN,
    ana_route: `LPM_RST_ANA_ROUTE,
    default: '0
  };

  lpm_state_s st;
  lpm_state_s next_st;

  logic lcd_en;
  logic [1:0] lcd_type_field;
  logic general_serial_enable;
  lpm_pins_t lcd_sel;
  lpm_pins_t lcd_lvl;
  lpm_pins_t alt_sel;
  lpm_pins_t alt_out;
  lpm_pins_t alt_oe;
  lpm_pins_t cell_out;
  lpm_pins_t cell_oe;

  assign lcd_en = st.lcd_control_register[`LPM_LCD_EN_BIT];
  assign lcd_type_field = st.lcd_control_register[`LPM_LCD_TYPE_MSB:`LPM_LCD_TYPE_LSB];
  assign general_serial_enable = st.peripheral_control_zero[`LPM_SERIAL_EN_BIT];

  // per-pin selection, decoded straight from the live register values
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      if (gi < 4) begin : g_com
        assign lcd_sel[gi] = lcd_en; // RULE_01
        assign lcd_lvl[gi] = lcd_backplane_lines[gi];
      end else if (gi == 4 || gi == 5) begin : g_p4_low
        assign lcd_sel[gi] = lcd_en;
        assign lcd_lvl[gi] = (lcd_type_field == 2'h0) ? lcd_segment_lines[gi-4] : lcd_backplane_lines[gi]; // RULE_02
      end else if (gi == 12 || gi == 13) begin : g_p5_low
        assign lcd_sel[gi] = lcd_en;
        assign lcd_lvl[gi] = (lcd_type_field < 2'h2) ? lcd_segment_lines[gi-4] : lcd_backplane_lines[gi-6]; // RULE_03
      end else begin : g_seg
        assign lcd_sel[gi] = st.seg_en[gi-4]; // RULE_04 RULE_05
        assign lcd_lvl[gi] = lcd_segment_lines[gi-4];
      end
      if (gi == NPIN - 1) begin : g_p90
        assign alt_sel[gi] = st.port9_function_select[`LPM_P90_TIMER_BIT]; // RULE_05
        assign alt_out[gi] = timer_a_channel_zero_out;
        assign alt_oe[gi] = timer_a_channel_zero_oe;
      end else begin : g_noalt
        assign alt_sel[gi] = 1'b0;
        assign alt_out[gi] = 1'b0;
        assign alt_oe[gi] = 1'b0;
      end
      lpm_pin_cell u_cell (
        .gpio_out(gpio_out[gi]),
        .gpio_oe(gpio_oe[gi]),
        .lcd_sel(lcd_sel[gi]),
        .lcd_level(lcd_lvl[gi]),
        .alt_sel(alt_sel[gi]),
        .alt_out(alt_out[gi]),
        .alt_oe(alt_oe[gi]),
        .pin_out(cell_out[gi]),
        .pin_oe(cell_oe[gi])
      );
    end
  endgenerate

  function automatic lpm_word_t merge_strb(input lpm_word_t old, input lpm_word_t data, input logic [3:0] strb);
    lpm_word_t res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_mapped(input lpm_addr_t a);
    logic [13:0] idx;
    idx = a[15:2];
    return (idx == `LPM_IDX_LCD_CTRL) || (idx == `LPM_IDX_PERI_CTRL0) || (idx == `LPM_IDX_PORT9_FS) ||
           (idx == `LPM_IDX_SEG_EN_LO) || (idx == `LPM_IDX_SEG_EN_HI) || (idx == `LPM_IDX_ANA_ROUTE) ||
           (idx == `LPM_IDX_FUNC_STATUS);
  endfunction

  lpm_func_e p90_func;
  lpm_func_e p91_func;

  always_comb begin
    if (st.seg_en[35]) begin
      p90_func = LPM_FN_LCD;
    end else if (st.port9_function_select[`LPM_P90_TIMER_BIT]) begin
      p90_func = LPM_FN_TIMER;
    end else begin
      p90_func = LPM_FN_GPIO;
    end
    if (general_serial_enable) begin
      p91_func = LPM_FN_SERIAL;
    end else if (st.port9_function_select[`LPM_P91_TIMER_BIT]) begin
      p91_func = LPM_FN_TIMER;
    end else begin
      p91_func = LPM_FN_GPIO;
    end
  end

  always_comb begin
    lpm_word_t wmerged;
    lpm_word_t rd;
    wmerged = '0;
    rd = '0;
    next_st = st;
    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_hold && st.w_hold) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = addr_mapped(st.aw_addr) ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
      case (st.aw_addr[15:2])
        `LPM_IDX_LCD_CTRL: begin
          wmerged = merge_strb({24'h000000, st.lcd_control_register}, st.w_data, st.w_strb);
          next_st.lcd_control_register = wmerged[7:0];
        end
        `LPM_IDX_PERI_CTRL0: begin
          wmerged = merge_strb({24'h000000, st.peripheral_control_zero}, st.w_data, st.w_strb);
          next_st.peripheral_control_zero = wmerged[7:0];
        end
        `LPM_IDX_PORT9_FS: begin
          wmerged = merge_strb({24'h000000, st.port9_function_select}, st.w_data, st.w_strb);
          next_st.port9_function_select = wmerged[7:0];
        end
        `LPM_IDX_SEG_EN_LO: begin
          wmerged = merge_strb(st.seg_en[31:0], st.w_data, st.w_strb);
          next_st.seg_en[31:0] = wmerged;
        end
        `LPM_IDX_SEG_EN_HI: begin
          wmerged = merge_strb({24'h000000, st.seg_en[39:32]}, st.w_data, st.w_strb);
          next_st.seg_en[39:32] = wmerged[7:0];
        end
        `LPM_IDX_ANA_ROUTE: begin
          wmerged = merge_strb({24'h000000, st.ana_route}, st.w_data, st.w_strb);
          next_st.ana_route = wmerged[7:0];
        end
        default: begin
          wmerged = '0;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // read channel: one read in flight, data captured at acceptance
    if (s_axi_arvalid && s_axi_arready) begin
      case (s_axi_araddr[15:2])
        `LPM_IDX_LCD_CTRL: rd = {24'h000000, st.lcd_control_register};
        `LPM_IDX_PERI_CTRL0: rd = {24'h000000, st.peripheral_control_zero};
        `LPM_IDX_PORT9_FS: rd = {24'h000000, st.port9_function_select};
        `LPM_IDX_SEG_EN_LO: rd = st.seg_en[31:0];
        `LPM_IDX_SEG_EN_HI: rd = {24'h000000, st.seg_en[39:32]};
        `LPM_IDX_ANA_ROUTE: rd = {24'h000000, st.ana_route};
        `LPM_IDX_FUNC_STATUS: rd = {21'h00000, st.cmp_sw, st.meas_sw, 2'h0, p91_func, p90_func};
        default: rd = '0;
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = addr_mapped(s_axi_araddr) ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // pin side: registered one clock after the selecting registers
    next_st.pin_out = cell_out; // RULE_11
    next_st.pin_oe = cell_oe;
    next_st.gpio_in = port_pin_in;
    next_st.tmr0_in = port_pin_in[NPIN-1];
    case (p91_func)
      LPM_FN_SERIAL: begin
        next_st.p91_out = serial_data_out; // RULE_06
        next_st.p91_oe = serial_data_oe;
      end
      LPM_FN_TIMER: begin
        next_st.p91_out = timer_a_channel_one_out;
        next_st.p91_oe = timer_a_channel_one_oe;
      end
      default: begin
        next_st.p91_out = p91_gpio_out;
        next_st.p91_oe = p91_gpio_oe;
      end
    endcase
    next_st.p91_gpio_in = p91_pin_in;
    next_st.tmr1_in = p91_pin_in;
    next_st.ser_in = p91_pin_in;
    // the reference pulse is an input only, so it may listen whatever drives
    next_st.ref_in = p91_pin_in; // RULE_07
    next_st.seg36_out = lcd_segment_lines[36]; // RULE_08
    next_st.ana_out = lcd_segment_lines[39:37];
    next_st.ana_oe = st.seg_en[39:37];
    // switches stay open while segment drive is on, guarding the analog front end
    next_st.meas_sw = st.ana_route[`LPM_ANA_MEAS_LSB +: 3] & ~st.seg_en[39:37]; // RULE_09 RULE_10
    next_st.cmp_sw = st.ana_route[`LPM_ANA_CMP_LSB +: 2] & ~st.seg_en[39:38]; // RULE_09 RULE_10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= RST_STATE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.aw_hold && !st.bvalid;
  assign s_axi_wready = !st.w_hold && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign port_pin_out = st.pin_out;
  assign port_pin_oe = st.pin_oe;
  assign gpio_in = st.gpio_in;
  assign p91_pin_out = st.p91_out;
  assign p91_pin_oe = st.p91_oe;
  assign p91_gpio_in = st.p91_gpio_in;
  assign timer_a_channel_zero_in = st.tmr0_in;
  assign timer_a_channel_one_in = st.tmr1_in;
  assign serial_data_in = st.ser_in;
  assign second_reference_pulse_in = st.ref_in;
  assign seg36_pin_out = st.seg36_out;
  assign analog_pin_out = st.ana_out;
  assign analog_pin_oe = st.ana_oe;
  assign analog_measure_inputs = st.meas_sw;
  assign analog_comparator_b = st.cmp_sw;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_com_pins;
    $past(ce) && $past(aresetn) |->
      port_pin_out[3:0] == ($past(lcd_en) ? $past(lcd_backplane_lines[3:0]) : $past(gpio_out[3:0]));
  endproperty
  a_com_pins: assert property (p_com_pins) else $error("port 3 pin function wrong"); // RULE_01

  property p_p4_low;
    $past(ce) && $past(aresetn) && $past(lcd_en) |-> port_pin_oe[5:4] == 2'h3 &&
      port_pin_out[5:4] == (($past(lcd_type_field) == 2'h0) ? $past(lcd_segment_lines[1:0])
                                                           : $past(lcd_backplane_lines[5:4]));
  endproperty
  a_p4_low: assert property (p_p4_low) else $error("P4.0/P4.1 lcd function wrong"); // RULE_02

  property p_p5_low;
    $past(ce) && $past(aresetn) && $past(lcd_en) |->
      port_pin_out[13:12] == (($past(lcd_type_field) < 2'h2) ? $past(lcd_segment_lines[9:8])
                                                            : $past(lcd_backplane_lines[7:6]));
  endproperty
  a_p5_low: assert property (p_p5_low) else $error("P5.0/P5.1 lcd function wrong"); // RULE_03

  property p_seg_enable;
    $past(ce) && $past(aresetn) |->
      port_pin_oe[6] == ($past(st.seg_en[2]) ? 1'b1 : $past(gpio_oe[6]));
  endproperty
  a_seg_enable: assert property (p_seg_enable) else $error("segment 2 enable not obeyed"); // RULE_04

  property p_p90_timer;
    $past(ce) && $past(aresetn) && !$past(st.seg_en[35]) && $past(st.port9_function_select[0]) |->
      port_pin_out[NPIN-1] == $past(timer_a_channel_zero_out) && port_pin_oe[NPIN-1] == $past(timer_a_channel_zero_oe);
  endproperty
  a_p90_timer: assert property (p_p90_timer) else $error("P9.0 timer function wrong"); // RULE_05

  property p_p91_serial;
    $past(ce) && $past(aresetn) && $past(general_serial_enable) |->
      p91_pin_out == $past(serial_data_out) && p91_pin_oe == $past(serial_data_oe);
  endproperty
  a_p91_serial: assert property (p_p91_serial) else $error("P9.1 serial data not routed"); // RULE_06

  property p_ref_pulse;
    ce && aresetn |=> second_reference_pulse_in == $past(p91_pin_in);
  endproperty
  a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse not taken from P9.1"); // RULE_07

  property p_seg36;
    ce ##1 ce |=> seg36_pin_out == $past(lcd_segment_lines[36]);
  endproperty
  a_seg36: assert property (p_seg36) else $error("segment 36 pin not driven"); // RULE_08

  property p_analog_route;
    $past(ce) && $past(aresetn) |->
      analog_measure_inputs[1] == ($past(st.ana_route[1]) && !$past(st.seg_en[38])) &&
      analog_comparator_b[0] == ($past(st.ana_route[3]) && !$past(st.seg_en[38]));
  endproperty
  a_analog_route: assert property (p_analog_route) else $error("M1 analog routing wrong"); // RULE_09

  property p_write_effect;
    st.aw_hold && st.w_hold && ce && st.aw_addr[15:2] == `LPM_IDX_LCD_CTRL && st.w_strb[0] ##1 ce |=>
      port_pin_oe[0] == ($past(st.w_data[0], 2) ? 1'b1 : $past(gpio_oe[0]));
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("lcd enable write not effective"); // RULE_11
endmodule

// >>> lpm_cfg.svh
/*
  Register indexes, field positions, reset values and bus answers of the
  LCD segment pin function mux. Included by the package and by the top
  module; assumes nothing else is defined under the LPM_ prefix.
*/
// Behaviour
// [RULE_01] port 3 pins 0-3 are GPIO after reset, selectable as backplanes 0-3.
// [RULE_02] port 4 pins 0-1: GPIO default; LCD type 0 gives segments 0-1, else backplanes 4-5.
// [RULE_03] port 5 pins 0-1: GPIO default; type 0/1 gives segments 8-9, type 2/3 backplanes 6-7.
// [RULE_04] P4.2-P4.7 and P5.2-P8.2 become segments only when their own enable bit is 1.
// [RULE_05] P9.0 picks fast GPIO or timer A channel 0 by port 9 select; also segment 35.
// [RULE_06] P9.1 picks fast GPIO or timer A channel 1; serial enable gives serial data.
// [RULE_07] P9.1 can take in an external one second reference pulse.
// [RULE_08] segment 36 pin is a dedicated segment output with no other function.
// [RULE_09] segment 37-39 pins route to measure inputs ANALOG_MEASURE_INPUTS; M1, M2 also to comparator.
// [RULE_10] software turns off segment drive on pins 37-39 before analog use.
// [RULE_11] pin functions decode from current register values, effective on the next clock.
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

`define LPM_NPORT_PIN 40
`define LPM_NSEG 40
`define LPM_NBP 8

// register indexes; byte address is four times the index
`define LPM_IDX_LCD_CTRL 14'h2c1e
`define LPM_IDX_PERI_CTRL0 14'h2d00
`define LPM_IDX_PORT9_FS 14'h00ad
`define LPM_IDX_SEG_EN_LO 14'h2c20
`define LPM_IDX_SEG_EN_HI 14'h2c21
`define LPM_IDX_ANA_ROUTE 14'h2c22
`define LPM_IDX_FUNC_STATUS 14'h2c23

`define LPM_LCD_EN_BIT 0
`define LPM_LCD_TYPE_LSB 4
`define LPM_LCD_TYPE_MSB 5
`define LPM_SERIAL_EN_BIT 6
`define LPM_P90_TIMER_BIT 0
`define LPM_P91_TIMER_BIT 1
`define LPM_ANA_MEAS_LSB 0
`define LPM_ANA_CMP_LSB 3

`define LPM_RST_LCD_CTRL 8'h00
`define LPM_RST_PERI_CTRL0 8'h00
`define LPM_RST_PORT9_FS 8'h00
`define LPM_RST_SEG_EN 40'h00_0000_0000
`define LPM_RST_ANA_ROUTE 8'h00

`define LPM_RESP_OKAY 2'h0
`define LPM_RESP_SLVERR 2'h2

`endif

// >>> lpm_pkg.sv
/*
  Types shared by the LCD segment pin function mux files.
  Assumes lpm_cfg.svh is on the include path.
*/
package lpm_pkg;
  `include "lpm_cfg.svh"

  typedef logic [`LPM_NPORT_PIN-1:0] lpm_pins_t;
  typedef logic [`LPM_NSEG-1:0] lpm_seg_t;
  typedef logic [`LPM_NBP-1:0] lpm_bp_t;
  typedef logic [15:0] lpm_addr_t;
  typedef logic [31:0] lpm_word_t;

  typedef enum logic [1:0] {
    LPM_FN_GPIO,
    LPM_FN_LCD,
    LPM_FN_TIMER,
    LPM_FN_SERIAL
  } lpm_func_e;

  typedef struct packed {
    logic aw_hold;
    lpm_addr_t aw_addr;
    logic w_hold;
    lpm_word_t w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    lpm_word_t rdata;
    logic [1:0] rresp;
    logic [7:0] lcd_control_register;
    logic [7:0] peripheral_control_zero;
    logic [7:0] port9_function_select;
    lpm_seg_t seg_en;
    logic [7:0] ana_route;
    lpm_pins_t pin_out;
    lpm_pins_t pin_oe;
    lpm_pins_t gpio_in;
    logic p91_out;
    logic p91_oe;
    logic p91_gpio_in;
    logic seg36_out;
    logic [2:0] ana_out;
    logic [2:0] ana_oe;
    logic [2:0] meas_sw;
    logic [1:0] cmp_sw;
    logic tmr0_in;
    logic tmr1_in;
    logic ser_in;
    logic ref_in;
  } lpm_state_s;
endpackage

// >>> lpm_pin_cell.sv
/*
  One multi-purpose port pin: picks the LCD level, an alternate peripheral
  or the GPIO driver. Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
module lpm_pin_cell (
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic lcd_sel,
  input wire logic lcd_level,
  input wire logic alt_sel,
  input wire logic alt_out,
  input wire logic alt_oe,
  output logic pin_out,
  output logic pin_oe
);
  import lpm_pkg::*;

  // lcd drive wins: an enabled segment must never be fought by a peripheral
  always_comb begin
    if (lcd_sel) begin
      pin_out = lcd_level;
      pin_oe = 1'b1;
    end else if (alt_sel) begin
      pin_out = alt_out;
      pin_oe = alt_oe;
    end else begin
      pin_out = gpio_out;
      pin_oe = gpio_oe;
    end
  end
endmodule

// >>> lpm_far_model.sv
/*
  Far side of the pin mux: LCD glass drive levels, timer A and serial
  drivers, and the board around the port pins.
  Assumes lpm_pkg is compiled first and the bench supplies the external levels.
*/
`timescale 1ns/100ps
module lpm_far_model (
  input wire logic flip,
  input wire lpm_pkg::lpm_pins_t port_pin_out,
  input wire lpm_pkg::lpm_pins_t port_pin_oe,
  input wire lpm_pkg::lpm_pins_t ext_pins,
  input wire logic p91_pin_out,
  input wire logic p91_pin_oe,
  input wire logic ext_p91,
  output lpm_pkg::lpm_pins_t port_pin_in,
  output logic p91_pin_in,
  output lpm_pkg::lpm_seg_t lcd_segment_lines,
  output lpm_pkg::lpm_bp_t lcd_backplane_lines,
  output logic timer_a_channel_zero_out,
  output logic timer_a_channel_zero_oe,
  output logic timer_a_channel_one_out,
  output logic timer_a_channel_one_oe,
  output logic serial_data_out,
  output logic serial_data_oe
);
  import lpm_pkg::*;
  // distinct levels per line so a wrong selection shows; flip swaps them all
  assign lcd_segment_lines = 40'h96_3c5a_a5c3 ^ {40{flip}};
  assign lcd_backplane_lines = 8'h6a ^ {8{flip}};
  assign timer_a_channel_zero_out = ~flip;
  assign timer_a_channel_zero_oe = 1'b1;
  assign timer_a_channel_one_out = flip;
  assign timer_a_channel_one_oe = 1'b0;
  assign serial_data_out = ~flip;
  assign serial_data_oe = 1'b1;
  // a pin the mux does not drive shows the level the board puts on it
  assign port_pin_in = (port_pin_out & port_pin_oe) | (ext_pins & ~port_pin_oe);
  assign p91_pin_in = p91_pin_oe ? p91_pin_out : ext_p91;
endmodule

// >>> lcd_segment_pin_function_mux_tb_top.sv
/*
  Self-checking bench of the pin mux: AXI4-Lite tasks, a reference of the
  pin selection, and the far side model. Assumes lpm_cfg.svh on the include path.
*/
`timescale 1ns/100ps
`include "lpm_cfg.svh"
module lcd_segment_pin_function_mux_tb_top;
  import lpm_pkg::*;
  localparam lpm_addr_t A_LCD = {`LPM_IDX_LCD_CTRL, 2'b00};
  localparam lpm_addr_t A_PERI = {`LPM_IDX_PERI_CTRL0, 2'b00};
  localparam lpm_addr_t A_FS = {`LPM_IDX_PORT9_FS, 2'b00};
  localparam lpm_addr_t A_SLO = {`LPM_IDX_SEG_EN_LO, 2'b00};
  localparam lpm_addr_t A_SHI = {`LPM_IDX_SEG_EN_HI, 2'b00};
  localparam lpm_addr_t A_ANA = {`LPM_IDX_ANA_ROUTE, 2'b00};
  localparam lpm_addr_t A_STAT = {`LPM_IDX_FUNC_STATUS, 2'b00};
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, flip = 1'b0, ext_p91 = 1'b0;
  lpm_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
  lpm_word_t s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, analog_comparator_b;
  lpm_pins_t gpio_out = 40'h5a_c3a5_0f96, gpio_oe = 40'hf0_0ff0_3cc3, ext_pins = 40'h3c_5a69_c3a5;
  lpm_pins_t gpio_in, port_pin_in, port_pin_out, port_pin_oe;
  logic p91_gpio_out = 1'b0, p91_gpio_oe = 1'b1;
  logic p91_gpio_in, p91_pin_in, p91_pin_out, p91_pin_oe, seg36_pin_out, second_reference_pulse_in;
  logic timer_a_channel_zero_out, timer_a_channel_zero_oe, timer_a_channel_zero_in;
  logic timer_a_channel_one_out, timer_a_channel_one_oe, timer_a_channel_one_in;
  logic serial_data_out, serial_data_oe, serial_data_in;
  lpm_seg_t lcd_segment_lines;
  lpm_bp_t lcd_backplane_lines;
  logic [2:0] analog_pin_out, analog_pin_oe, analog_measure_inputs;
  logic [7:0] lcd_ctrl = '0, peri = '0, fs = '0, ana = '0;
  lpm_seg_t seg_en = '0;
  int n_mismatch = 0, n_tests = 0;

  lpm_pin_mux dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_out,
    .gpio_oe, .gpio_in, .p91_gpio_out, .p91_gpio_oe, .p91_gpio_in, .lcd_segment_lines, .lcd_backplane_lines,
    .timer_a_channel_zero_out, .timer_a_channel_zero_oe, .timer_a_channel_zero_in, .timer_a_channel_one_out,
    .timer_a_channel_one_oe, .timer_a_channel_one_in, .serial_data_out, .serial_data_oe, .serial_data_in,
    .second_reference_pulse_in, .port_pin_in, .port_pin_out, .port_pin_oe, .p91_pin_in, .p91_pin_out,
    .p91_pin_oe, .seg36_pin_out, .analog_pin_out, .analog_pin_oe, .analog_measure_inputs, .analog_comparator_b);
  lpm_far_model far (.flip, .port_pin_out, .port_pin_oe, .ext_pins, .p91_pin_out, .p91_pin_oe, .ext_p91,
    .port_pin_in, .p91_pin_in, .lcd_segment_lines, .lcd_backplane_lines, .timer_a_channel_zero_out,
    .timer_a_channel_zero_oe, .timer_a_channel_one_out, .timer_a_channel_one_oe, .serial_data_out,
    .serial_data_oe);

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // tasks start just after a rising edge; requests held until taken
  task automatic axi_wr(input lpm_addr_t a, input lpm_word_t d, input logic [1:0] er);
    logic aw_ok, w_ok, aw_d, w_d, b_ok;
    logic [1:0] r;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      aw_d = aw_d | aw_ok;
      w_d = w_d | w_ok;
    end
    do begin
      @(negedge aclk);
      b_ok = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!b_ok);
    s_axi_bready <= 1'b0;
    chk("bresp", er, r);
    @(posedge aclk);
  endtask

  task automatic axi_rd(input lpm_addr_t a, input lpm_word_t ed, input logic [1:0] er);
    logic ok;
    lpm_word_t d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_arready;
      @(posedge aclk);
    end while (!ok);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!ok);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", er, r);
    @(posedge aclk);
  endtask

  // expected pins from the shadow registers
  task automatic check_all;
    lpm_pins_t eo, eoe;
    logic [1:0] po;
    @(negedge aclk);
    eo = gpio_out;
    eoe = gpio_oe;
    for (int k = 2; k < 36; k++) begin
      if (seg_en[k] && k != 8 && k != 9) begin
        eo[4+k] = lcd_segment_lines[k];
        eoe[4+k] = 1'b1;
      end
    end
    if (!seg_en[35] && fs[0]) {eo[39], eoe[39]} = {timer_a_channel_zero_out, timer_a_channel_zero_oe};
    if (lcd_ctrl[0]) begin
      eo[3:0] = lcd_backplane_lines[3:0];
      eo[5:4] = lcd_ctrl[5:4] == 2'd0 ? lcd_segment_lines[1:0] : lcd_backplane_lines[5:4];
      eo[13:12] = lcd_ctrl[5:4] < 2'd2 ? lcd_segment_lines[9:8] : lcd_backplane_lines[7:6];
      eoe[5:0] = 6'h3f;
      eoe[13:12] = 2'h3;
    end
    po = peri[6] ? {serial_data_out, serial_data_oe} :
      fs[1] ? {timer_a_channel_one_out, timer_a_channel_one_oe} : {p91_gpio_out, p91_gpio_oe};
    chk("port_pin_out", eo, port_pin_out);
    chk("port_pin_oe", eoe, port_pin_oe);
    chk("p91_pin", po, {p91_pin_out, p91_pin_oe});
    chk("seg36_pin_out", lcd_segment_lines[36], seg36_pin_out);
    chk("analog_pin", {lcd_segment_lines[39:37], seg_en[39:37]}, {analog_pin_out, analog_pin_oe});
    chk("measure", ana[2:0] & ~seg_en[39:37], analog_measure_inputs);
    chk("comparator", ana[4:3] & ~seg_en[39:38], analog_comparator_b);
    repeat (2) @(negedge aclk);
    chk("gpio_in", port_pin_in, gpio_in);
    chk("timer0_in", port_pin_in[39], timer_a_channel_zero_in);
    chk("p91_inputs", {4{p91_pin_in}}, {timer_a_channel_one_in, serial_data_in, p91_gpio_in,
      second_reference_pulse_in});
    @(posedge aclk);
  endtask

  task automatic setreg(input lpm_addr_t a, input lpm_word_t d);
    axi_wr(a, d, `LPM_RESP_OKAY);
    case (a)
      A_LCD: lcd_ctrl = d[7:0];
      A_PERI: peri = d[7:0];
      A_FS: fs = d[7:0];
      A_SLO: seg_en[31:0] = d;
      A_SHI: seg_en[39:32] = d[7:0];
      A_ANA: ana = d[7:0];
      default: ;
    endcase
    check_all();
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    lpm_addr_t regs[7];
    regs = '{A_LCD, A_PERI, A_FS, A_SLO, A_SHI, A_ANA, A_STAT};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_all();
    foreach (regs[i]) axi_rd(regs[i], 32'h0, `LPM_RESP_OKAY);
    axi_rd(16'h0040, 32'h0, `LPM_RESP_SLVERR);
    axi_wr(16'h0040, 32'hffff_ffff, `LPM_RESP_SLVERR);
    for (int t = 0; t < 4; t++) begin
      setreg(A_LCD, {26'h0, t[1:0], 4'h1});
      axi_rd(A_LCD, {26'h0, t[1:0], 4'h1}, `LPM_RESP_OKAY);
    end
    flip <= 1'b1;
    @(posedge aclk);
    check_all();
    setreg(A_SLO, 32'h0000_0c05);
    setreg(A_SHI, 32'h0000_0004);
    setreg(A_FS, 32'h0000_0001);
    setreg(A_SHI, 32'h0000_000c);
    setreg(A_FS, 32'h0000_0003);
    setreg(A_PERI, 32'h0000_0040);
    axi_rd(A_STAT, 32'h0000_000d, `LPM_RESP_OKAY);
    // segment drive on 37-39 stays off before analog routing
    setreg(A_ANA, 32'h0000_001f);
    axi_rd(A_STAT, 32'h0000_07cd, `LPM_RESP_OKAY);
    axi_wr(A_STAT, 32'h0, `LPM_RESP_OKAY);
    axi_rd(A_STAT, 32'h0000_07cd, `LPM_RESP_OKAY);
    setreg(A_SHI, 32'h0000_002c);
    setreg(A_PERI, 32'h0);
    setreg(A_FS, 32'h0);
    p91_gpio_oe <= 1'b0;
    ext_p91 <= 1'b1;
    @(posedge aclk);
    check_all();
    ext_p91 <= 1'b0;
    @(posedge aclk);
    check_all();
    ce <= 1'b0;
    flip <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("frozen", !lcd_segment_lines[36], seg36_pin_out);
    print_verdict();
  end
endmodule
